// ===== design/rtcw_calendar.sv
// Running calendar counters with load and rollover.
`include "rtcw_cfg.svh"

module rtcw_calendar (
  // Clock, reset and enable.
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // Control.
  input  wire logic        load_i,
  input  wire logic        enable_i,
  input  wire logic        tick_i,
  // Load values.
  input  wire logic [28:0] dt_load_i,
  input  wire logic [13:0] year_preset_i,
  // Current calendar.
  output logic [28:0]      datetime_o,
  output logic [13:0]      year_current_o
);

  rtcw_pkg::rtcw_cal_st_t q;
  rtcw_pkg::rtcw_cal_st_t d;
  logic c_min, c_hour, c_day, c_mon, c_year;

  // Divisible by four for a two digit BCD pair.
  function automatic logic rtcw_div4(input logic [3:0] t, input logic [3:0] o);
    return t[0] ? (o == 4'h2 || o == 4'h6) : (o == 4'h0 || o == 4'h4 || o == 4'h8);
  endfunction

  // Gregorian leap year on a BCD year: centuries only when divisible by 400.
  function automatic logic rtcw_leap(input logic [13:0] y);
    if (y[7:0] == 8'h00) begin
      return rtcw_div4({2'b00, y[13:12]}, y[11:8]);
    end
    return rtcw_div4(y[7:4], y[3:0]);
  endfunction

  // Length of a month in days.
  function automatic logic [4:0] rtcw_mlen(input logic [3:0] m, input logic lp);
    unique case (m)
      4'h2:                      return lp ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB:    return 5'h1E;
      default:                   return 5'h1F;
    endcase
  endfunction

  // BCD increment of the year; the top digit holds only 0 to 3 and wraps.
  function automatic logic [13:0] rtcw_year_inc(input logic [13:0] y);
    logic [13:0] r;
    r = y;
    if (y[3:0] != 4'h9) begin
      r[3:0] = y[3:0] + 4'h1;
    end else begin
      r[3:0] = 4'h0;
      if (y[7:4] != 4'h9) begin
        r[7:4] = y[7:4] + 4'h1;
      end else begin
        r[7:4] = 4'h0;
        if (y[11:8] != 4'h9) begin
          r[11:8] = y[11:8] + 4'h1;
        end else begin
          r[11:8]  = 4'h0;
          r[13:12] = y[13:12] + 2'h1;
        end
      end
    end
    return r;
  endfunction

  // Load has priority over a tick that lands in the same cycle.
  always_comb begin
    d      = q;
    c_min  = q.sec == `RTCW_SEC_MAX;
    c_hour = c_min && q.min == `RTCW_MIN_MAX;
    c_day  = c_hour && q.hour == `RTCW_HOUR_MAX;
    c_mon  = c_day && q.mday == rtcw_mlen(q.mon, rtcw_leap(q.year));
    c_year = c_mon && q.mon == `RTCW_MON_MAX;
    if (load_i) begin
      d.sec  = dt_load_i[`RTCW_SEC_HI:`RTCW_SEC_LO]; // see (R16)
      d.min  = dt_load_i[`RTCW_MIN_HI:`RTCW_MIN_LO];
      d.hour = dt_load_i[`RTCW_HOUR_HI:`RTCW_HOUR_LO];
      d.wday = dt_load_i[`RTCW_WDAY_HI:`RTCW_WDAY_LO];
      d.mday = dt_load_i[`RTCW_MDAY_HI:`RTCW_MDAY_LO];
      d.mon  = dt_load_i[`RTCW_MON_HI:`RTCW_MON_LO];
      d.year = year_preset_i;
    end else if (tick_i && enable_i) begin
      d.sec = c_min ? 6'h00 : q.sec + 6'h01; // see (R15)
      if (c_min) begin
        d.min = c_hour ? 6'h00 : q.min + 6'h01;
      end
      if (c_hour) begin
        d.hour = c_day ? 5'h00 : q.hour + 5'h01;
      end
      if (c_day) begin
        d.wday = (q.wday == `RTCW_WDAY_MAX) ? 3'h1 : q.wday + 3'h1; // see (R4)
        d.mday = c_mon ? 5'h01 : q.mday + 5'h01;
      end
      if (c_mon) begin
        d.mon = c_year ? 4'h1 : q.mon + 4'h1; // see (R6)
      end
      if (c_year) begin
        d.year = rtcw_year_inc(q.year);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q      <= '0;
      q.wday <= `RTCW_RST_WDAY;
      q.mday <= `RTCW_RST_MDAY;
      q.mon  <= `RTCW_RST_MON;
      q.year <= `RTCW_RST_YEAR_CUR;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign datetime_o     = {q.mon, q.mday, q.wday, q.hour, q.min, q.sec};
  assign year_current_o = q.year;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_tick_mid;
    ce_i && tick_i && enable_i && !load_i && !c_min;
  endsequence

  AST_SEC_ADVANCE: assert property ( // see (R15)
    s_tick_mid |=> q.sec == $past(q.sec) + 6'h01 && $stable(q.min))
    else $error("seconds did not advance by one on a tick");

  AST_LOAD_TAKEN: assert property ( // see (R16)
    (ce_i && load_i) |=> (datetime_o == $past(dt_load_i) && year_current_o == $past(year_preset_i)))
    else $error("calendar did not take the load values");

  AST_WDAY_WRAP: assert property ( // see (R4)
    (ce_i && tick_i && enable_i && !load_i && c_day && q.wday == 3'h7) |=> q.wday == 3'h1)
    else $error("weekday did not wrap from Saturday to Sunday");

endmodule

// ===== design/rtcw_cfg.svh
// Offsets, field positions, reset values and counts of the clockwatch block.
`ifndef RTCW_CFG_SVH
`define RTCW_CFG_SVH

// Register byte offsets.
`define RTCW_OFF_DT_LOAD    8'h08
`define RTCW_OFF_YEAR_CUR   8'h0C
`define RTCW_OFF_YEAR_CMP   8'h10
`define RTCW_OFF_YEAR_PRE   8'h14
`define RTCW_OFF_CONTROL    8'h18
`define RTCW_OFF_IRQ_STAT   8'h40
`define RTCW_OFF_IRQ_MASK   8'h44

// Date/time load field positions.
`define RTCW_SEC_HI   5
`define RTCW_SEC_LO   0
`define RTCW_MIN_HI   11
`define RTCW_MIN_LO   6
`define RTCW_HOUR_HI  16
`define RTCW_HOUR_LO  12
`define RTCW_WDAY_HI  19
`define RTCW_WDAY_LO  17
`define RTCW_MDAY_HI  24
`define RTCW_MDAY_LO  20
`define RTCW_MON_HI   28
`define RTCW_MON_LO   25

// Control field positions.
`define RTCW_DIV_HI   14
`define RTCW_DIV_LO   0
`define RTCW_TRIM_HI  25
`define RTCW_TRIM_LO  16
`define RTCW_EN_BIT   26

// Reset values.
`define RTCW_RST_YEAR_CUR   14'h2000
`define RTCW_RST_YEAR_CMP   14'h2000
`define RTCW_RST_YEAR_PRE   14'h0000
`define RTCW_RST_DIV        15'h7FFF
`define RTCW_RST_TRIM       10'h000
`define RTCW_RST_WDAY       3'h1
`define RTCW_RST_MDAY       5'h01
`define RTCW_RST_MON        4'h1

// Counts and limits.
`define RTCW_TRIM_PERIOD    10'h3FF
`define RTCW_SEC_MAX        6'h3B
`define RTCW_MIN_MAX        6'h3B
`define RTCW_HOUR_MAX       5'h17
`define RTCW_WDAY_MAX       3'h7
`define RTCW_MON_MAX        4'hC

`endif

// ===== design/rtcw_pkg.sv
// State types of the clockwatch block.
package rtcw_pkg;

  typedef struct packed {
    logic [5:0]  sec;
    logic [5:0]  min;
    logic [4:0]  hour;
    logic [2:0]  wday;
    logic [4:0]  mday;
    logic [3:0]  mon;
    logic [13:0] year;
  } rtcw_cal_st_t;

  typedef struct packed {
    logic        s0;
    logic        s1;
    logic        s2;
    logic [9:0]  per_cnt;
    logic [9:0]  del_cnt;
    logic [14:0] div_cnt;
    logic        tick;
    logic        feed;
  } rtcw_tick_st_t;

  typedef struct packed {
    logic [28:0] dt_load;
    logic [13:0] year_compare;
    logic [13:0] year_preset;
    logic [14:0] tick_divider;
    logic [9:0]  trim_pulse_delete;
    logic        calendar_enable_lock;
    logic        start;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic        irq;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic        hready;
  } rtcw_top_st_t;

endpackage

// ===== design/rtcw_tick.sv
// Slow clock synchroniser, trim pulse deletion and one second divider.
`include "rtcw_cfg.svh"

module rtcw_tick (
  // Clock, reset and enable.
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  // Slow clock pin.
  input  wire logic        slow_clock_i,
  // Settings.
  input  wire logic [14:0] tick_divider_i,
  input  wire logic [9:0]  trim_pulse_delete_i,
  // Results.
  output logic             one_second_tick_o,
  output logic             timer_feed_o
);

  rtcw_pkg::rtcw_tick_st_t q;
  rtcw_pkg::rtcw_tick_st_t d;
  logic                    edge_seen;
  logic                    keep;

  // Each slow rising edge is one slow cycle; deleted edges never reach the divider.
  always_comb begin
    d         = q;
    d.s0      = slow_clock_i;
    d.s1      = q.s0;
    d.s2      = q.s1;
    edge_seen = q.s1 & ~q.s2;
    keep      = edge_seen && !(q.del_cnt < trim_pulse_delete_i); // see (R12)
    d.tick    = 1'b0;
    d.feed    = 1'b0;
    if (edge_seen) begin
      if (q.per_cnt == (`RTCW_TRIM_PERIOD - 10'h001)) begin
        d.per_cnt = 10'h000;
        d.del_cnt = 10'h000; // see (R12)
      end else begin
        d.per_cnt = q.per_cnt + 10'h001;
        if (!keep) begin
          d.del_cnt = q.del_cnt + 10'h001;
        end
      end
    end
    if (keep) begin
      if (tick_divider_i == 15'h0000) begin
        d.div_cnt = 15'h0000; // see (R11)
        d.feed    = 1'b1;
      end else if (q.div_cnt >= tick_divider_i) begin
        d.div_cnt = 15'h0000; // see (R10)
        d.tick    = 1'b1;
        d.feed    = 1'b1;
      end else begin
        d.div_cnt = q.div_cnt + 15'h0001;
      end
    end
  end

  // Reset wins over the clock enable so the block always leaves reset clean.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign one_second_tick_o = q.tick;
  assign timer_feed_o      = q.feed;

  // Helper for the period check: kept edges since the last tick at a stable divider.
  logic [14:0] gap_q;
  logic [14:0] div_q;
  logic        seen_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gap_q  <= 15'h0000;
      div_q  <= 15'h0000;
      seen_q <= 1'b0;
    end else if (ce_i) begin
      div_q <= tick_divider_i;
      if (keep) begin
        gap_q  <= d.tick ? 15'h0000 : gap_q + 15'h0001;
        seen_q <= (tick_divider_i == div_q) && (seen_q || d.tick);
      end else if (tick_divider_i != div_q) begin
        seen_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_TICK_PERIOD: assert property ( // see (R10)
    (ce_i && keep && d.tick && seen_q && tick_divider_i == div_q) |-> gap_q == tick_divider_i)
    else $error("tick period differs from divider plus one");

  AST_DIV_ZERO: assert property ( // see (R11)
    (ce_i && tick_divider_i == 15'h0000 && keep) |=> (timer_feed_o && !one_second_tick_o))
    else $error("zero divider must feed timer and stop tick");

  AST_TRIM_DELETE: assert property ( // see (R12)
    (ce_i && edge_seen && q.del_cnt < trim_pulse_delete_i)
      |=> ($stable(q.div_cnt) && !timer_feed_o && !one_second_tick_o))
    else $error("deleted slow pulse reached the divider");

endmodule

// ===== design/rtcw_top.sv
// Clockwatch load and control registers on an AHB-Lite slave, with interrupt.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`include "rtcw_cfg.svh"

// Behaviour
// (R1) Software loads seconds 0 to 59 only into bits 5:0.
// (R2) Software loads minutes 0 to 59 only into bits 11:6.
// (R3) Software loads hours 0 to 23 only into bits 16:12.
// (R4) Weekday codes 1 Sunday to 7 Saturday; code 0 never written.
// (R5) Software loads day of month within the month's true length.
// (R6) Month codes 1 January to 12 December; nothing else written.
// (R7) Current BCD year is read only, bits 13:0, resets to 2000.
// (R8) Year compare value is read-write BCD, resets to 2000.
// (R9) Year preset value is read-write BCD, resets to zero.
// (R10) One tick every divider plus one slow cycles; reset divider 7FFF.
// (R11) Zero divider feeds timer with slow clock and stops the tick.
// (R12) Delete trim count slow pulses in each 1023-cycle period.
// (R13) Divider and trim writes ignored while enabled; reads return stored values.
// (R14) Enable bit starts clockwatch and locks the control register until reset.
// (R15) Each tick advances seconds with full calendar rollover and leap years.
// (R16) Load registers hold values; counters take them when the clockwatch starts.
module rtcw_top (
  // Clock, reset and enable.
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        CLK_EN_I,
  // AHB-Lite slave.
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic [31:0]      HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // Slow clock pin.
  input  wire logic        SLOW_CLOCK_I,
  // Results.
  output logic             ONE_SECOND_TICK_O,
  output logic             TIMER_FEED_O,
  output logic [28:0]      CAL_DATETIME_O,
  output logic             IRQ_O
);

  rtcw_pkg::rtcw_top_st_t q;
  rtcw_pkg::rtcw_top_st_t d;
  logic [13:0]            year_current;
  logic                   sec_tick;
  logic                   addr_phase;
  logic                   rd_clear;
  logic [1:0]             events;

  // Read multiplexer; unmapped offsets and reserved bits read as zero.
  function automatic logic [31:0] rtcw_read(input logic [7:0] a,
                                            input rtcw_pkg::rtcw_top_st_t s,
                                            input logic [13:0] yc);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `RTCW_OFF_DT_LOAD:  r[28:0] = s.dt_load;
      `RTCW_OFF_YEAR_CUR: r[13:0] = yc; // see (R7)
      `RTCW_OFF_YEAR_CMP: r[13:0] = s.year_compare;
      `RTCW_OFF_YEAR_PRE: r[13:0] = s.year_preset;
      `RTCW_OFF_CONTROL: begin
        r[`RTCW_DIV_HI:`RTCW_DIV_LO]   = s.tick_divider; // see (R13)
        r[`RTCW_TRIM_HI:`RTCW_TRIM_LO] = s.trim_pulse_delete;
        r[`RTCW_EN_BIT]                = s.calendar_enable_lock;
      end
      `RTCW_OFF_IRQ_STAT: r[1:0] = s.status;
      `RTCW_OFF_IRQ_MASK: r[1:0] = s.mask;
      default:            r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Divider and trim deletion from the synchronised slow clock.
  rtcw_tick u_tick (
    .clk_i               (CORE_CLK_I),
    .rst_n_i             (RESET_N_I),
    .ce_i                (CLK_EN_I),
    .slow_clock_i        (SLOW_CLOCK_I),
    .tick_divider_i      (q.tick_divider),
    .trim_pulse_delete_i (q.trim_pulse_delete),
    .one_second_tick_o   (sec_tick),
    .timer_feed_o        (TIMER_FEED_O)
  );

  // Calendar counters; the start pulse copies the load registers in.
  rtcw_calendar u_cal (
    .clk_i          (CORE_CLK_I),
    .rst_n_i        (RESET_N_I),
    .ce_i           (CLK_EN_I),
    .load_i         (q.start), // see (R16)
    .enable_i       (q.calendar_enable_lock),
    .tick_i         (sec_tick),
    .dt_load_i      (q.dt_load),
    .year_preset_i  (q.year_preset),
    .datetime_o     (CAL_DATETIME_O),
    .year_current_o (year_current)
  );

  // Bus decode, register writes, read data and interrupt status.
  always_comb begin
    d          = q;
    d.start    = 1'b0;
    d.hready   = 1'b1;
    addr_phase = HSEL_I && HTRANS_I[1] && HREADY_I;
    rd_clear   = 1'b0;
    // Write data arrives one cycle after its address phase.
    if (q.wr_pend) begin
      unique case (q.wr_addr)
        `RTCW_OFF_DT_LOAD:  d.dt_load      = HWDATA_I[28:0]; // see (R16)
        `RTCW_OFF_YEAR_CMP: d.year_compare = HWDATA_I[13:0]; // see (R8)
        `RTCW_OFF_YEAR_PRE: d.year_preset  = HWDATA_I[13:0]; // see (R9)
        `RTCW_OFF_CONTROL: begin
          // Once started, the whole register is frozen until power-on reset.
          if (!q.calendar_enable_lock) begin
            d.tick_divider         = HWDATA_I[`RTCW_DIV_HI:`RTCW_DIV_LO]; // see (R13)
            d.trim_pulse_delete    = HWDATA_I[`RTCW_TRIM_HI:`RTCW_TRIM_LO];
            d.calendar_enable_lock = HWDATA_I[`RTCW_EN_BIT]; // see (R14)
            d.start                = HWDATA_I[`RTCW_EN_BIT];
          end
        end
        `RTCW_OFF_IRQ_MASK: d.mask = HWDATA_I[1:0];
        default: begin
        end
      endcase
    end
    d.wr_pend = addr_phase && HWRITE_I;
    d.wr_addr = HADDR_I[7:0];
    // Read data is registered in the address phase and stands in the data phase.
    if (addr_phase && !HWRITE_I) begin
      d.rdata  = rtcw_read(HADDR_I[7:0], q, year_current);
      rd_clear = HADDR_I[7:0] == `RTCW_OFF_IRQ_STAT;
    end
    // Bit 0 is the second tick, bit 1 the tick on which the year matches.
    events[0] = sec_tick && q.calendar_enable_lock;
    events[1] = events[0] && (year_current == q.year_compare); // see (R8)
    // A new event beats the clear of a read in the same cycle.
    d.status = (rd_clear ? 2'b00 : q.status) | events;
    d.irq    = |(d.status & d.mask);
  end

  // Reset acts regardless of the clock enable.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      q                   <= '0;
      q.year_compare      <= `RTCW_RST_YEAR_CMP;
      q.year_preset       <= `RTCW_RST_YEAR_PRE;
      q.tick_divider      <= `RTCW_RST_DIV;
      q.trim_pulse_delete <= `RTCW_RST_TRIM;
      q.hready            <= 1'b1;
    end else if (CLK_EN_I) begin
      q <= d;
    end
  end

  // Second tick is registered once more so the output matches the status update.
  logic tick_out_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      tick_out_q <= 1'b0;
    end else if (CLK_EN_I) begin
      tick_out_q <= sec_tick;
    end
  end

  assign ONE_SECOND_TICK_O = tick_out_q;
  assign HRDATA_O          = q.rdata;
  assign HREADYOUT_O       = q.hready;
  assign HRESP_O           = 1'b0;
  assign IRQ_O             = q.irq;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_ctrl_write;
    CLK_EN_I && q.wr_pend && q.wr_addr == `RTCW_OFF_CONTROL;
  endsequence

  AST_CTRL_LOCKED: assert property ( // see (R13)
    q.calendar_enable_lock |=> ($stable(q.tick_divider) && $stable(q.trim_pulse_delete)))
    else $error("divider or trim changed while clockwatch enabled");

  AST_LOCK_STAYS: assert property ( // see (R14)
    q.calendar_enable_lock |=> q.calendar_enable_lock)
    else $error("enable lock fell without reset");

  AST_START_LOADS: assert property ( // see (R14)
    (s_ctrl_write and (!q.calendar_enable_lock && HWDATA_I[`RTCW_EN_BIT]))
      |=> (q.start && q.calendar_enable_lock) ##1 !q.start)
    else $error("enable write did not start the clockwatch once");

  AST_YEAR_RESET: assert property ( // see (R7)
    $rose(RESET_N_I) |-> (year_current == 14'h2000 && q.year_compare == 14'h2000
                          && q.year_preset == 14'h0000))
    else $error("year registers not at reset values");

  AST_YEAR_RO: assert property ( // see (R7)
    (CLK_EN_I && addr_phase && !HWRITE_I && HADDR_I[7:0] == `RTCW_OFF_YEAR_CUR)
      |=> HRDATA_O == {18'h00000, $past(year_current)})
    else $error("year read does not show the running year");

  AST_PRESET_WRITE: assert property ( // see (R9)
    (CLK_EN_I && q.wr_pend && q.wr_addr == `RTCW_OFF_YEAR_PRE)
      |=> q.year_preset == $past(HWDATA_I[13:0]))
    else $error("year preset write not stored");

  AST_IRQ_LEVEL: assert property (
    IRQ_O == |(q.status & q.mask))
    else $error("interrupt level disagrees with masked status");

  AST_DIV_RESET: assert property ( // see (R10)
    $rose(RESET_N_I) |-> q.tick_divider == 15'h7FFF)
    else $error("divider not at reset value");

  // A read of the status register, whose clear races with new events.
  sequence s_stat_read;
    CLK_EN_I && addr_phase && !HWRITE_I
      && HADDR_I[7:0] == `RTCW_OFF_IRQ_STAT;
  endsequence

  // A second tick while the clockwatch runs.
  sequence s_run_tick;
    CLK_EN_I && sec_tick && q.calendar_enable_lock;
  endsequence

  // A read of the control register.
  sequence s_ctrl_read;
    CLK_EN_I && addr_phase && !HWRITE_I
      && HADDR_I[7:0] == `RTCW_OFF_CONTROL;
  endsequence

  // Zero wait states and an OKAY answer, so a master never stalls here.
  AST_BUS_OKAY: assert property (
    HREADYOUT_O && !HRESP_O)
    else $error("slave stretched a transfer or gave an error");

  // Every running tick is an event for the interrupt logic.
  AST_TICK_STATUS: assert property ( // see (R15)
    s_run_tick |=> q.status[0])
    else $error("running tick did not set status");

  AST_MATCH_STATUS: assert property ( // see (R8)
    (s_run_tick and (year_current == q.year_compare))
      |=> q.status[1])
    else $error("year match tick did not set status");

  // The clear of a read must not hide a tick that lands in the same cycle.
  AST_SET_WINS: assert property (
    (s_stat_read and s_run_tick) |=> q.status[0])
    else $error("status clear swallowed a new tick");

  // Without a new event a status read leaves nothing behind.
  AST_STAT_CLEAR: assert property (
    (s_stat_read and !sec_tick) |=> q.status == 2'b00)
    else $error("status read did not clear");

  AST_CTRL_READ: assert property ( // see (R13)
    s_ctrl_read |=> HRDATA_O == {5'h00, $past(q.calendar_enable_lock),
      $past(q.trim_pulse_delete), 1'b0, $past(q.tick_divider)})
    else $error("control read differs from stored fields");

  AST_DIV_WRITE: assert property ( // see (R10)
    (s_ctrl_write and !q.calendar_enable_lock)
      |=> q.tick_divider == $past(HWDATA_I[`RTCW_DIV_HI:`RTCW_DIV_LO]))
    else $error("unlocked divider write not stored");

  AST_TRIM_WRITE: assert property ( // see (R12)
    (s_ctrl_write and !q.calendar_enable_lock)
      |=> q.trim_pulse_delete == $past(HWDATA_I[`RTCW_TRIM_HI:`RTCW_TRIM_LO]))
    else $error("unlocked trim write not stored");

  // Plain register writes land at the end of their data phase.
  AST_CMP_WRITE: assert property ( // see (R8)
    (CLK_EN_I && q.wr_pend && q.wr_addr == `RTCW_OFF_YEAR_CMP)
      |=> q.year_compare == $past(HWDATA_I[13:0]))
    else $error("year compare write not stored");

  AST_LOAD_WRITE: assert property ( // see (R16)
    (CLK_EN_I && q.wr_pend && q.wr_addr == `RTCW_OFF_DT_LOAD)
      |=> q.dt_load == $past(HWDATA_I[28:0]))
    else $error("date and time load write not stored");

  AST_MASK_WRITE: assert property (
    (CLK_EN_I && q.wr_pend && q.wr_addr == `RTCW_OFF_IRQ_MASK)
      |=> q.mask == $past(HWDATA_I[1:0]))
    else $error("interrupt mask write not stored");

  // Before the start nothing may move the calendar, not even a tick.
  AST_IDLE_CAL: assert property ( // see (R14)
    (CLK_EN_I && !q.calendar_enable_lock && !q.start)
      |=> $stable(CAL_DATETIME_O) && $stable(year_current))
    else $error("calendar moved before the start");

  // The port pulse trails the internal tick by exactly one cycle.
  AST_TICK_OUT: assert property ( // see (R10)
    (CLK_EN_I && sec_tick) |=> ONE_SECOND_TICK_O)
    else $error("tick output did not follow the tick");

  // Read data must stand through the data phase and after it.
  AST_RD_HOLD: assert property (
    (CLK_EN_I && !(addr_phase && !HWRITE_I)) |=> $stable(HRDATA_O))
    else $error("read data changed without a read");

endmodule

// ===== tb/tb_top.sv
// Self-checking testbench of the clockwatch load and control register block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Bus, slow clock and result signals of the block.
  logic        core_clk;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        slow_clock;
  logic        tick;
  logic        feed;
  logic [28:0] cal;
  logic        irq;
  int          n_mismatch;
  int          n_checks;
  logic [31:0] rd;
  int          nf;
  int          nt;

  // Calendar just before New Year, and the same moment two ticks on.
  localparam logic [28:0] dt_eve = {4'hC, 5'h1F, 3'h7, 5'h17, 6'h3B, 6'h3A};
  localparam logic [28:0] dt_new = {4'h1, 5'h01, 3'h1, 5'h00, 6'h00, 6'h00};

  // Free-running 50 MHz core clock.
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  rtcw_top DUT (
    .CORE_CLK_I        (core_clk),
    .RESET_N_I         (reset_n),
    .CLK_EN_I          (1'b1),
    .HSEL_I            (hsel),
    .HADDR_I           (haddr),
    .HTRANS_I          (htrans),
    .HWRITE_I          (hwrite),
    .HSIZE_I           (3'h2),
    .HWDATA_I          (hwdata),
    .HREADY_I          (hready),
    .HRDATA_O          (hrdata),
    .HREADYOUT_O       (hready),
    .HRESP_O           (hresp),
    .SLOW_CLOCK_I      (slow_clock),
    .ONE_SECOND_TICK_O (tick),
    .TIMER_FEED_O      (feed),
    .CAL_DATETIME_O    (cal),
    .IRQ_O             (irq)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one value with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for hready; a hung slave counts as a mismatch and ends the run.
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) begin
      chk({31'h0, hready}, 32'h1);
      finish_test();
    end
  endtask

  // One single AHB-Lite transfer, then an idle cycle so a read never overlaps a write.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask

  // Power-on reset held for 16 cycles; the slow clock stays low meanwhile.
  task automatic do_reset;
    reset_n    <= 1'b0;
    slow_clock <= 1'b0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
  endtask

  // Slow clock edges, long enough for the synchroniser, counting every pulse.
  task automatic slow_edges(input int n, output int f, output int t);
    f = 0;
    t = 0;
    repeat (n) begin
      slow_clock <= 1'b1;
      repeat (4) begin
        @(posedge core_clk);
        f += (feed === 1'b1);
        t += (tick === 1'b1);
      end
      slow_clock <= 1'b0;
      repeat (8) begin
        @(posedge core_clk);
        f += (feed === 1'b1);
        t += (tick === 1'b1);
      end
    end
  endtask

  // Reset values of the load, year and control registers, an unmapped place and the ports.
  task automatic t_reset_vals;
    rchk(8'h08, 32'h0);
    rchk(8'h0C, 32'h0000_2000);
    rchk(8'h10, 32'h0000_2000);
    rchk(8'h14, 32'h0);
    rchk(8'h18, 32'h0000_7FFF);
    rchk(8'h30, 32'h0);
    chk({3'h0, cal}, {3'h0, dt_new});
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset values done");
  endtask

  // Load and year registers keep their fields; reserved bits and the read-only year do not.
  task automatic t_regs;
    wr(8'h10, 32'hFFFF_1999);
    rchk(8'h10, 32'h0000_1999);
    wr(8'h14, 32'hFFFF_1999);
    rchk(8'h14, 32'h0000_1999);
    wr(8'h08, {3'h7, dt_eve});
    rchk(8'h08, {3'h0, dt_eve});
    wr(8'h0C, 32'h0000_1234);
    rchk(8'h0C, 32'h0000_2000);
    $display("test registers done");
  endtask

  // Start, lock, ticking and the New Year rollover with interrupt.
  task automatic t_clock;
    wr(8'h18, 32'h0400_0001);
    wr(8'h18, 32'h0000_0003);
    rchk(8'h18, 32'h0400_0001);
    chk({3'h0, cal}, {3'h0, dt_eve});
    slow_edges(2, nf, nt);
    chk(nt, 1);
    chk({3'h0, cal}, {3'h0, dt_eve + 29'h1});
    chk({31'h0, irq}, 32'h0);
    rchk(8'h40, 32'h3);
    wr(8'h44, 32'h1);
    slow_edges(2, nf, nt);
    chk(nt, 1);
    chk(nf, 1);
    chk({3'h0, cal}, {3'h0, dt_new});
    chk({31'h0, irq}, 32'h1);
    rchk(8'h0C, 32'h0000_2000);
    bus(1'b0, 8'h40, 32'h0, rd);
    chk(rd & 32'h1, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rchk(8'h40, 32'h0);
    $display("test clockwatch done");
  endtask

  // Reset releases the lock; trim deletion and the undivided timer feed.
  task automatic t_trim;
    rchk(8'h18, 32'h0000_7FFF);
    wr(8'h18, 32'h0002_0000);
    rchk(8'h18, 32'h0002_0000);
    slow_edges(5, nf, nt);
    chk(nf, 3);
    chk(nt, 0);
    wr(8'h18, 32'h0);
    slow_edges(3, nf, nt);
    chk(nf, 3);
    chk(nt, 0);
    $display("test trim done");
  endtask

  // Main sequence with every input given a value at time zero.
  initial begin
    n_mismatch = 0;
    n_checks   = 0;
    reset_n    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hwdata     = 32'h0;
    slow_clock = 1'b0;
    @(posedge core_clk);
    do_reset();
    t_reset_vals();
    t_regs();
    t_clock();
    do_reset();
    t_trim();
    finish_test();
  end
endmodule
